// >>> src/serial_tx_pkg.sv
/*
  Constants for the transmit status/control block: register offsets,
  bit positions, reset values, mode codes and frame lengths.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package serial_tx_pkg;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] TXDATA_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  // Bit positions in serial_status_control
  localparam int IRQSEL1_BIT = 15;
  localparam int INVERT_BIT = 14;
  localparam int IRQSEL0_BIT = 13;
  localparam int RXEN_BIT = 12;
  localparam int BREAK_BIT = 11;
  localparam int TXEN_BIT = 10;
  localparam int BUFFULL_BIT = 9;
  localparam int SHEMPTY_BIT = 8;
  // Bit positions in the control register
  localparam int MODON_BIT = 0;
  localparam int INFRARED_ENCODER_ENABLE_BIT = 1;
  // Byte lanes
  localparam int LANE_HI = 1;
  localparam int LANE_LO = 0;
  // Transmit interrupt modes
  localparam logic [1:0] IRQ_EACH = 2'h0;
  localparam logic [1:0] IRQ_DONE = 2'h1;
  localparam logic [1:0] IRQ_BUFEMPTY = 2'h2;
  localparam logic [1:0] IRQ_RESVD = 2'h3;
  // Frame shapes, LSB first
  localparam logic [4:0] CHAR_BITS = 5'h0A;
  localparam logic [4:0] BREAK_BITS = 5'h0E;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Default bit period in clocks
  localparam int BIT_CLKS = 868;
endpackage : serial_tx_pkg

// >>> src/baud_tick.sv
/*
  Bit period timer: one-cycle tick at the end of every bit period.
  Assumes restart_i pulses when a frame is loaded so bit edges align.
*/
`timescale 1ns/1ps
module baud_tick #(
  parameter int DIV = serial_tx_pkg::BIT_CLKS
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic restart_i, // Restart the period
  output logic tick_o // End of bit period
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_reg;
  wire at_end = (cnt_reg == LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || at_end) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Combinational so that every bit, the first too, lasts exactly DIV clocks
  assign tick_o = at_end;
endmodule : baud_tick

// >>> src/serial_tx_ctrl.sv
/*
  Transmit side status and control of an asynchronous serial port with a
  one-character buffer, shift register, sync break and event output.
  Assumes a classic Wishbone master and an outside pin mux that honours
  the output enables.
*/
// The register offsets and register access over Wishbone were left to the implementer.
// What this block does
// - The two-bit interrupt select picks when the transmit event fires, code 11 never fires.
// - Transmit enable, while the module-on bit is set, hands the output pin to the port, clearing it aborts and empties the buffer.
// - A requested break sends start, twelve zeros and stop, and the request clears itself after.
// - The buffer-full flag is read-only and shows that no further character is accepted, except in the cycle the buffer loads the shift register.
// - The shift-empty flag is read-only and is one only with shift register and buffer empty.
// - Polarity invert flips every line bit, the idle level too, and only while the infrared encoder is enabled.
`timescale 1ns/1ps
module serial_tx_ctrl #(
  parameter int BIT_DIV = serial_tx_pkg::BIT_CLKS
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic serial_out_o, // Transmit line level
  output logic serial_out_oe_o, // Transmitter owns the pin
  output logic serial_in_owned_o, // Receiver owns the input pin
  output logic tx_irq_o // Transmit event pulse
);
  // Register state
  logic [1:0] irq_sel_reg;
  logic invert_reg, rx_en_reg, break_req_reg, tx_en_reg;
  logic module_on_reg, ir_en_reg;
  logic buf_full_reg, busy_reg, is_break_reg;
  logic [7:0] buf_data_reg;
  logic [13:0] shift_reg;
  logic [4:0] bits_left_reg;
  logic [31:0] rdata_next;

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_now = req && wb_ack_o && wb_we_i;
  wire hit_status = (wb_adr_i == serial_tx_pkg::STATUS_OFS);
  wire hit_data = (wb_adr_i == serial_tx_pkg::TXDATA_OFS);
  wire hit_ctrl = (wb_adr_i == serial_tx_pkg::CTRL_OFS);
  wire wr_status_hi = wr_now && hit_status && wb_sel_i[serial_tx_pkg::LANE_HI];
  wire wr_ctrl = wr_now && hit_ctrl && wb_sel_i[serial_tx_pkg::LANE_LO];
  wire wr_char = wr_now && hit_data && wb_sel_i[serial_tx_pkg::LANE_LO];

  // Transmit engine control
  wire tx_on = tx_en_reg && module_on_reg;
  wire tick;
  wire load_char = tx_on && !busy_reg && !break_req_reg && buf_full_reg;
  wire load_break = tx_on && !busy_reg && break_req_reg;
  wire frame_end = busy_reg && tick && (bits_left_reg == 5'h01);
  wire char_taken = wr_char && tx_on && (!buf_full_reg || load_char);
  wire shift_empty = !busy_reg && !buf_full_reg;
  wire line_bit = busy_reg ? shift_reg[0] : 1'b1;
  wire flip = ir_en_reg && invert_reg;

  wire ev_each = load_char;
  wire ev_bufempty = load_char && !char_taken;
  wire ev_done = frame_end && !is_break_reg && !buf_full_reg;
  wire irq_next = (irq_sel_reg == serial_tx_pkg::IRQ_EACH) ? ev_each :
                  (irq_sel_reg == serial_tx_pkg::IRQ_BUFEMPTY) ? ev_bufempty :
                  (irq_sel_reg == serial_tx_pkg::IRQ_DONE) ? ev_done : 1'b0;

  baud_tick #(.DIV(BIT_DIV)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(load_char || load_break),
    .tick_o(tick)
  );

  // Read mux, low byte belongs to the receiver and reads zero here
  always_comb begin
    rdata_next = serial_tx_pkg::ZERO_WORD;
    if (hit_status) begin
      rdata_next[serial_tx_pkg::IRQSEL1_BIT] = irq_sel_reg[1];
      rdata_next[serial_tx_pkg::INVERT_BIT] = invert_reg;
      rdata_next[serial_tx_pkg::IRQSEL0_BIT] = irq_sel_reg[0];
      rdata_next[serial_tx_pkg::RXEN_BIT] = rx_en_reg;
      rdata_next[serial_tx_pkg::BREAK_BIT] = break_req_reg;
      rdata_next[serial_tx_pkg::TXEN_BIT] = tx_en_reg;
      rdata_next[serial_tx_pkg::BUFFULL_BIT] = buf_full_reg;
      rdata_next[serial_tx_pkg::SHEMPTY_BIT] = shift_empty;
    end else if (hit_ctrl) begin
      rdata_next[serial_tx_pkg::MODON_BIT] = module_on_reg;
      rdata_next[serial_tx_pkg::INFRARED_ENCODER_ENABLE_BIT] = ir_en_reg;
    end
  end

  // Single-wait-state slave, unmapped addresses ack with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= serial_tx_pkg::ZERO_WORD;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= rdata_next;
    end
  end

  // Control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sel_reg <= serial_tx_pkg::IRQ_EACH;
      invert_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      module_on_reg <= 1'b0;
      ir_en_reg <= 1'b0;
    end else begin
      if (wr_status_hi) begin
        irq_sel_reg <= {wb_dat_i[serial_tx_pkg::IRQSEL1_BIT],
                        wb_dat_i[serial_tx_pkg::IRQSEL0_BIT]};
        invert_reg <= wb_dat_i[serial_tx_pkg::INVERT_BIT];
        rx_en_reg <= wb_dat_i[serial_tx_pkg::RXEN_BIT];
        tx_en_reg <= wb_dat_i[serial_tx_pkg::TXEN_BIT];
      end
      if (wr_ctrl) begin
        module_on_reg <= wb_dat_i[serial_tx_pkg::MODON_BIT];
        ir_en_reg <= wb_dat_i[serial_tx_pkg::INFRARED_ENCODER_ENABLE_BIT];
      end
    end
  end

  // software set wins over hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_on) begin
      break_req_reg <= 1'b0;
    end else if (wr_status_hi) begin
      break_req_reg <= wb_dat_i[serial_tx_pkg::BREAK_BIT];
    end else if (frame_end && is_break_reg) begin
      break_req_reg <= 1'b0;
    end
  end

  // disable aborts and empties the buffer
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_on) begin
      buf_full_reg <= 1'b0;
      buf_data_reg <= 8'h00;
    end else if (char_taken) begin
      buf_full_reg <= 1'b1;
      buf_data_reg <= wb_dat_i[7:0];
    end else if (load_char) begin
      buf_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_on) begin
      busy_reg <= 1'b0;
      is_break_reg <= 1'b0;
      shift_reg <= '0;
      bits_left_reg <= 5'h00;
    end else if (load_break) begin
      busy_reg <= 1'b1;
      is_break_reg <= 1'b1;
      shift_reg <= serial_tx_pkg::BREAK_FRAME;
      bits_left_reg <= serial_tx_pkg::BREAK_BITS;
    end else if (load_char) begin
      busy_reg <= 1'b1;
      is_break_reg <= 1'b0;
      shift_reg <= {4'h0, 1'b1, buf_data_reg, 1'b0};
      bits_left_reg <= serial_tx_pkg::CHAR_BITS;
    end else if (busy_reg && tick) begin
      shift_reg <= {1'b0, shift_reg[13:1]};
      bits_left_reg <= bits_left_reg - 5'h01;
      busy_reg <= !frame_end;
    end
  end

  // Pins and event output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_o <= 1'b1;
      serial_out_oe_o <= 1'b0;
      serial_in_owned_o <= 1'b0;
      tx_irq_o <= 1'b0;
    end else begin
      serial_out_o <= line_bit ^ flip;
      serial_out_oe_o <= tx_on;
      serial_in_owned_o <= rx_en_reg && module_on_reg;
      tx_irq_o <= irq_next;
    end
  end

  // Checks
  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  oe_follows_en_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_on |=> !serial_out_oe_o && !buf_full_reg && !busy_reg)
    else $error("disabled transmitter still active");
  resvd_silent_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_sel_reg == serial_tx_pkg::IRQ_RESVD |=> !tx_irq_o)
    else $error("reserved mode fired event");
  each_fires_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_char && irq_sel_reg == serial_tx_pkg::IRQ_EACH |=> tx_irq_o)
    else $error("transfer event missing");
  break_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_break |=> busy_reg && is_break_reg && bits_left_reg == serial_tx_pkg::BREAK_BITS)
    else $error("break frame length wrong");
  break_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(break_req_reg) && tx_on |-> $past(frame_end) || $past(wr_status_hi))
    else $error("break request cleared early");
  full_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    buf_full_reg && !load_char && tx_on |=> buf_full_reg && $stable(buf_data_reg))
    else $error("full buffer changed");
  empty_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rdata_next[serial_tx_pkg::SHEMPTY_BIT] && hit_status) |-> !busy_reg && !buf_full_reg)
    else $error("shift empty while occupied");
  idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy_reg && !ir_en_reg |=> serial_out_o)
    else $error("idle level inverted without encoder");
  rx_owned_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_en_reg |=> !serial_in_owned_o)
    else $error("receiver holds pin while disabled");
  ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one wait");
  irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_irq_o |=> !tx_irq_o)
    else $error("transmit event longer than one cycle");
  done_fires_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_done && irq_sel_reg == serial_tx_pkg::IRQ_DONE |=> tx_irq_o)
    else $error("last character event missing");
  bufempty_fires_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_char && !char_taken && irq_sel_reg == serial_tx_pkg::IRQ_BUFEMPTY |=> tx_irq_o)
    else $error("buffer empty event missing");
  break_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_reg && is_break_reg && bits_left_reg > 5'h01 |-> !shift_reg[0])
    else $error("break frame bit not zero");
  break_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_reg && is_break_reg && bits_left_reg == 5'h01 |-> shift_reg[0])
    else $error("break frame stop bit missing");
  break_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    break_req_reg && tx_on && !wr_status_hi && !(frame_end && is_break_reg)
    |=> break_req_reg)
    else $error("break request dropped before its frame");
  break_keeps_buf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_break && !char_taken |=> $stable(buf_full_reg))
    else $error("break frame consumed the buffer");
  char_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_char |=> !shift_reg[0] && shift_reg[9] &&
      bits_left_reg == serial_tx_pkg::CHAR_BITS)
    else $error("character frame shape wrong");
  oe_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_on |=> serial_out_oe_o)
    else $error("enabled transmitter does not own pin");
  taken_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    char_taken |=> buf_full_reg)
    else $error("accepted character not buffered");
  load_empties_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_char && !char_taken |=> !buf_full_reg)
    else $error("buffer still full after load");
  frame_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end |=> !busy_reg)
    else $error("shift register busy after frame end");
  empty_rises_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && !buf_full_reg && !char_taken |=> shift_empty)
    else $error("shift empty missing after last frame");
  invert_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy_reg && flip |=> !serial_out_o)
    else $error("inverted idle level missing");
  rx_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_en_reg && module_on_reg |=> serial_in_owned_o)
    else $error("enabled receiver does not own pin");

  // Cycles since the last bit edge, for the bit period check
  localparam int AGE_W = $clog2(BIT_DIV + 1);
  logic [AGE_W-1:0] bit_age_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || load_char || load_break || (busy_reg && tick)) begin
      bit_age_reg <= '0;
    end else if (bit_age_reg != '1) begin
      bit_age_reg <= bit_age_reg + AGE_W'(1);
    end
  end
  bit_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_reg && tick |-> bit_age_reg == AGE_W'(BIT_DIV - 1))
    else $error("bit period not one divider span");

  // Main scenarios
  char_sent_c: cover property (@(posedge clk_i) disable iff (rst_i)
    frame_end && !is_break_reg);
  break_sent_c: cover property (@(posedge clk_i) disable iff (rst_i)
    frame_end && is_break_reg);
  abort_c: cover property (@(posedge clk_i) disable iff (rst_i)
    busy_reg && $fell(tx_en_reg));
  done_event_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ev_done && irq_sel_reg == serial_tx_pkg::IRQ_DONE);
  full_refused_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_char && buf_full_reg && !load_char);
endmodule : serial_tx_ctrl

// >>> tb/serial_line_model.sv
/*
  Far-side receiver of the transmit line: decodes characters and breaks.
  Assumes the line idles high and bits last DIV clocks.
*/
`timescale 1ns/1ps
module serial_line_model #(
  parameter int DIV = 4
) (
  input wire logic clk_i, // System clock
  input wire logic line_i, // Transmit line
  input wire logic oe_i, // Line driven by port
  output logic [7:0] byte_o, // Last character
  output int frames_o, // Characters seen
  output int breaks_o, // Break frames seen
  output int zeros_o // Zero bits after start in last break
);
  logic [8:0] sh;
  initial begin
    frames_o = 0;
    breaks_o = 0;
    zeros_o = 0;
    byte_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (oe_i && !line_i) begin
        repeat (DIV / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
          repeat (DIV) @(posedge clk_i);
          sh[i] = line_i;
        end
        if (sh[8]) begin
          byte_o = sh[7:0];
          frames_o++;
        end else begin
          zeros_o = 9;
          repeat (DIV) @(posedge clk_i);
          while (!line_i) begin
            zeros_o++;
            repeat (DIV) @(posedge clk_i);
          end
          breaks_o++;
        end
      end
    end
  end
endmodule : serial_line_model

// >>> tb/uart_tx_status_control_bench.sv
/*
  Self-checking bench of the transmit status/control block.
  Waits for every Wishbone ack; assumes a bit period of 4 clocks.
*/
`timescale 1ns/1ps
module uart_tx_status_control_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic wb_ack_o, serial_out_o, serial_out_oe_o, serial_in_owned_o, tx_irq_o;
  logic [7:0] rx_byte;
  int frames, breaks, zeros, irq_cnt = 0, err_total = 0, checked = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  serial_tx_ctrl #(.BIT_DIV(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .serial_in_owned_o(serial_in_owned_o), .tx_irq_o(tx_irq_o));
  serial_line_model #(.DIV(4)) far (.clk_i(clk_i), .line_i(serial_out_o),
    .oe_i(serial_out_oe_o), .byte_o(rx_byte), .frames_o(frames), .breaks_o(breaks),
    .zeros_o(zeros));
  always @(posedge clk_i) begin
    cycles++;
    if (tx_irq_o === 1'b1) irq_cnt++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : bus
  function automatic logic [31:0] stat(input logic [1:0] m, input logic inv, brk, en);
    stat = {16'h0000, m[1], inv, m[0], en, brk, en, 2'h0, 8'h00};
  endfunction : stat
  task automatic wait_idle();
    do begin
      bus(1'b0, serial_tx_pkg::STATUS_OFS, 32'h0000_0000);
    end while (rd[8] !== 1'b1 || rd[11] !== 1'b0);
    repeat (8) @(posedge clk_i);
  endtask : wait_idle
  // Pin outputs follow a register write one edge later; look mid-cycle
  task automatic settle();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic t_reset_map();
    bus(1'b0, serial_tx_pkg::STATUS_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    check({serial_out_o, serial_out_oe_o, serial_in_owned_o}, 3'h4);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test reset_map done");
  endtask : t_reset_map
  task automatic t_modes();
    int f;
    bus(1'b1, serial_tx_pkg::CTRL_OFS, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      f = frames;
      bus(1'b1, serial_tx_pkg::STATUS_OFS, stat(m[1:0], 1'b0, 1'b0, 1'b1));
      settle();
      check({serial_out_oe_o, serial_in_owned_o}, 2'h3);
      irq_cnt = 0;
      bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_00A0 + m);
      wait_idle();
      check(rd, stat(m[1:0], 1'b0, 1'b0, 1'b1) | 32'h0000_0100);
      check(irq_cnt, (m == 3) ? 0 : 1);
      check({rx_byte, 24'(frames - f)}, {8'hA0 + 8'(m), 24'h000001});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_full_break();
    int f = frames;
    int b = breaks;
    bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_0011);
    bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_0022);
    bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_0033);
    bus(1'b0, serial_tx_pkg::STATUS_OFS, 32'h0000_0000);
    check(rd[9:8], 2'h2);
    wait_idle();
    check({rx_byte, 24'(frames - f)}, {8'h22, 24'h000002});
    bus(1'b1, serial_tx_pkg::STATUS_OFS, stat(2'h0, 1'b0, 1'b1, 1'b1));
    bus(1'b0, serial_tx_pkg::STATUS_OFS, 32'h0000_0000);
    check(rd[11:8], 4'hC);
    wait_idle();
    check(rd, stat(2'h0, 1'b0, 1'b0, 1'b1) | 32'h0000_0100);
    check({24'(breaks - b), 8'(zeros)}, {24'h000001, 8'h0C});
    $display("test full_break done");
  endtask : t_full_break
  task automatic t_invert_abort();
    bus(1'b1, serial_tx_pkg::STATUS_OFS, stat(2'h0, 1'b1, 1'b0, 1'b1));
    settle();
    check(serial_out_o, 1'b1);
    bus(1'b1, serial_tx_pkg::CTRL_OFS, 32'h0000_0003);
    settle();
    check(serial_out_o, 1'b0);
    bus(1'b1, serial_tx_pkg::CTRL_OFS, 32'h0000_0001);
    bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_0055);
    bus(1'b1, serial_tx_pkg::TXDATA_OFS, 32'h0000_0066);
    bus(1'b1, serial_tx_pkg::STATUS_OFS, stat(2'h0, 1'b0, 1'b0, 1'b0));
    settle();
    check({serial_out_oe_o, serial_in_owned_o}, 2'h0);
    bus(1'b0, serial_tx_pkg::STATUS_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    $display("test invert_abort done");
  endtask : t_invert_abort
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_map();
    t_modes();
    t_full_break();
    t_invert_abort();
    give_verdict();
  end
endmodule : uart_tx_status_control_bench
